// [src/bpr_pkg.sv]
package bpr_pkg;

    // ----------------------------------------------------------------
    // Register indices
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_OUTPUT = 4'h1;
    localparam logic [3:0] ADDR_STATE = 4'h2;
    localparam logic [3:0] ADDR_FUNC = 4'h3;
    localparam logic [3:0] ADDR_BAL_LOW = 4'h4;
    localparam logic [3:0] ADDR_CELL_SEL = 4'h5;
    localparam logic [3:0] ADDR_OVERVOLTAGE_CONFIG = 4'h6;
    localparam logic [3:0] ADDR_UNDERVOLTAGE_CONFIG = 4'h7;
    localparam logic [3:0] ADDR_OL_UVD = 4'h8;
    localparam logic [3:0] ADDR_OL_DLY = 4'h9;
    localparam logic [3:0] ADDR_SC_CFG = 4'ha;
    localparam logic [3:0] ADDR_EE_EN = 4'hb;
    localparam int REG_COUNT = 12;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int OUT_RELEASE_BIT = 0;
    localparam int OUT_DSG_BIT = 1;
    localparam int OUT_CHG_BIT = 2;
    localparam int OUT_OPEN_DRAIN_BIT = 3;
    localparam int OUT_PARITY_BIT = 6;
    localparam int OUT_FAST_BIT = 7;
    localparam int STATE_SHUTDOWN_REQUEST_BIT = 0;
    localparam int STATE_HOST_BIT = 1;
    localparam int STATE_VSCALE_BIT = 6;
    localparam int STATE_CURRENT_AMP_GAIN_SELECT_BIT = 7;

    // Writable masks; other bits read as zero, except output bit 6, which reads the parity flag.
    localparam logic [7:0] OUTPUT_WR_MASK = 8'h8f;
    localparam logic [7:0] STATE_WR_MASK = 8'hc3;
    localparam logic [7:0] CELL_SEL_WR_MASK = 8'h7f;
    localparam logic [7:0] UNDERVOLTAGE_CONFIG_WR_MASK = 8'h7f;

    // ----------------------------------------------------------------
    // Reset values and codes
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] EE_CODE_ACCESS = 8'h62;
    localparam logic [7:0] EE_CODE_WRITE = 8'h41;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 125_000_000;
    localparam int FAST_SAMPLE_US = 100;
    localparam int SLOW_SAMPLE_MS = 50;
    localparam int FAST_SAMPLE_CYC = FAST_SAMPLE_US * (CLK_HZ / 1_000_000);
    localparam int SLOW_SAMPLE_CYC = SLOW_SAMPLE_MS * (CLK_HZ / 1_000);

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic charge_fet_on;
        logic discharge_fet_on;
        logic eeprom_supply_ok;
        logic thermal_fault;
        logic cell_low_fault;
        logic cell_high_fault;
        logic discharge_overload_flag;
        logic short_circuit_flag;
    } bpr_sense_t;

    typedef struct packed {
        logic cell_amp_enable;
        logic current_amp_enable;
        logic current_offset_output;
        logic pack_total_select;
        logic supply_total_select;
        logic thermistor_power;
        logic cell_amp_scale;
        logic current_amp_gain_select;
    } bpr_analog_t;

    typedef enum logic [2:0] {
        REL_IDLE = 3'b001,
        REL_HIGH = 3'b010,
        REL_DONE = 3'b100
    } bpr_rel_t;

endpackage : bpr_pkg

// [src/bpr_regs.sv]
`timescale 1ns/1ns
`default_nettype none

module bpr_regs
    import bpr_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Register access port.
    input wire logic [3:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Protection core interface.
    input wire bpr_sense_t sense_i,
    input wire logic parity_fault_i,
    input wire logic pack_zero_i,
    output logic host_mode_o,
    output logic fault_latch_release_o,
    output logic discharge_fet_o,
    output logic charge_fet_o,
    output logic fault_alert_n_o,
    output logic shutdown_o,
    output logic sample_tick_o,
    // Analog and pin controls.
    output logic open_drain_output_oe_o,
    output bpr_analog_t analog_o,
    output logic [9:0] balance_bypass_o,
    output logic [7:0] cell_sel_o,
    output logic [7:0] eeprom_enable_o
);

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    logic [7:0] output_drive;
    logic [7:0] operating_state;
    logic [7:0] analog_function_enables;
    logic [7:0] balance_bypass_low;
    logic [7:0] cell_translation_select;
    logic [7:0] cfg [6:10];
    logic [7:0] eeprom_write_enable;
    logic [7:0] fault_latch;
    logic parity_seen;
    logic alert_pending;
    bpr_rel_t rel_state;
    logic [22:0] sample_cnt;
    logic rd_status;

    // Write strobe decode for one address.
    function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] target);
        wr_hit = reg_wr_i && (a == target);
    endfunction : wr_hit

    // Voltage faults hold off any release.
    logic volt_fault;
    assign volt_fault = sense_i.cell_high_fault | sense_i.cell_low_fault;
    assign rd_status = reg_rd_i && (reg_addr_i == ADDR_STATUS);

    // Control registers, unused bits masked.
    // register writes
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            output_drive <= REG_RESET;
            operating_state <= REG_RESET;
            analog_function_enables <= REG_RESET;
            balance_bypass_low <= REG_RESET;
            cell_translation_select <= REG_RESET;
        end else begin
            if (wr_hit(reg_addr_i, ADDR_OUTPUT)) begin
                output_drive <= reg_wdata_i & OUTPUT_WR_MASK;
            end
            if (wr_hit(reg_addr_i, ADDR_STATE)) begin
                operating_state <= reg_wdata_i & STATE_WR_MASK;
            end
            if (wr_hit(reg_addr_i, ADDR_FUNC)) begin
                analog_function_enables <= reg_wdata_i;
            end
            if (wr_hit(reg_addr_i, ADDR_BAL_LOW)) begin
                balance_bypass_low <= reg_wdata_i;
            end
            if (wr_hit(reg_addr_i, ADDR_CELL_SEL)) begin
                cell_translation_select <= reg_wdata_i & CELL_SEL_WR_MASK;
            end
        end
    end

    // Threshold and delay configuration registers.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            for (int i = 6; i <= 10; i++) begin
                cfg[i] <= REG_RESET;
            end
        end else begin
            for (int i = 6; i <= 10; i++) begin
                if (wr_hit(reg_addr_i, 4'(i))) begin
                    cfg[i] <= (i == 7) ? (reg_wdata_i & UNDERVOLTAGE_CONFIG_WR_MASK) : reg_wdata_i;
                end
            end
        end
    end

    // EEPROM enable keeps only the two accepted codes.
    // code filter
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            eeprom_write_enable <= REG_RESET;
        end else if (wr_hit(reg_addr_i, ADDR_EE_EN)) begin
            if (reg_wdata_i == EE_CODE_ACCESS || reg_wdata_i == EE_CODE_WRITE) begin
                eeprom_write_enable <= reg_wdata_i;
            end else begin
                eeprom_write_enable <= REG_RESET;
            end
        end
    end

    // ----------------------------------------------------------------
    // Fault latch release sequence
    // ----------------------------------------------------------------
    // Tracks the release bit going 0, 1, then 0.
    // toggle detect
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rel_state <= REL_IDLE;
        end else begin
            unique case (rel_state)
                REL_IDLE: begin
                    if (output_drive[OUT_RELEASE_BIT] && !volt_fault) begin
                        rel_state <= REL_HIGH;
                    end
                end
                REL_HIGH: begin
                    if (volt_fault) begin
                        rel_state <= REL_IDLE;
                    end else if (!output_drive[OUT_RELEASE_BIT]) begin
                        rel_state <= REL_DONE;
                    end
                end
                REL_DONE: begin
                    rel_state <= REL_IDLE;
                end
                default: begin
                    rel_state <= REL_IDLE;
                end
            endcase
        end
    end
    assign fault_latch_release_o = (rel_state == REL_DONE);

    // Latched fault bits; a live fault wins over a release.
    // latch release
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            fault_latch <= REG_RESET;
        end else if (fault_latch_release_o && operating_state[STATE_HOST_BIT]) begin
            fault_latch <= {4'h0, sense_i[3:0]};
        end else begin
            fault_latch <= fault_latch | {4'h0, sense_i[3:0]};
        end
    end

    // Parity fault stays set until reset.
    // parity flag
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            parity_seen <= 1'b0;
        end else if (parity_fault_i) begin
            parity_seen <= 1'b1;
        end
    end

    // Alert held low in host mode until the latch is empty and status is read; outside host mode it clears once faults end; parity holds it until reset.
    // alert clear
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            alert_pending <= 1'b0;
        end else if ((|sense_i[4:0]) || parity_fault_i) begin
            alert_pending <= 1'b1;
        end else if (!operating_state[STATE_HOST_BIT]) begin
            alert_pending <= 1'b0;
        end else if (rd_status && (fault_latch[3:0] == 4'h0)) begin
            alert_pending <= 1'b0;
        end
    end
    assign fault_alert_n_o = !(alert_pending || parity_seen);

    // ----------------------------------------------------------------
    // Sampling tick divider
    // ----------------------------------------------------------------
    // sampling interval
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            sample_cnt <= '0;
        end else if (sample_tick_o) begin
            sample_cnt <= '0;
        end else begin
            sample_cnt <= sample_cnt + 23'd1;
        end
    end
    assign sample_tick_o = output_drive[OUT_FAST_BIT]
                         ? (sample_cnt >= 23'(FAST_SAMPLE_CYC - 1))
                         : (sample_cnt >= 23'(SLOW_SAMPLE_CYC - 1));

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    // status layout
    always_comb begin
        unique case (reg_addr_i)
            // live FET, supply and thermal bits plus live or latched cell, overload and short faults
            ADDR_STATUS: reg_rdata_o = sense_i | fault_latch;
            ADDR_OUTPUT: reg_rdata_o = output_drive | {1'b0, parity_seen, 6'h00};
            ADDR_STATE: reg_rdata_o = operating_state;
            ADDR_FUNC: reg_rdata_o = analog_function_enables;
            ADDR_BAL_LOW: reg_rdata_o = balance_bypass_low;
            ADDR_CELL_SEL: reg_rdata_o = cell_translation_select;
            ADDR_OVERVOLTAGE_CONFIG, ADDR_UNDERVOLTAGE_CONFIG, ADDR_OL_UVD, ADDR_OL_DLY,
            ADDR_SC_CFG: reg_rdata_o = cfg[reg_addr_i];
            ADDR_EE_EN: reg_rdata_o = eeprom_write_enable;
            default: reg_rdata_o = 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // mode select
    assign host_mode_o = operating_state[STATE_HOST_BIT];
    assign discharge_fet_o = host_mode_o && output_drive[OUT_DSG_BIT];
    assign charge_fet_o = host_mode_o && output_drive[OUT_CHG_BIT];
    assign open_drain_output_oe_o = output_drive[OUT_OPEN_DRAIN_BIT];
    assign shutdown_o = host_mode_o && operating_state[STATE_SHUTDOWN_REQUEST_BIT] && pack_zero_i;

    // Analog controls.
    always_comb begin
        analog_o.cell_amp_enable = analog_function_enables[0];
        analog_o.current_amp_enable = analog_function_enables[1];
        analog_o.current_offset_output = analog_function_enables[2];
        analog_o.supply_total_select = analog_function_enables[0] && analog_function_enables[4];
        analog_o.pack_total_select = analog_function_enables[0] && analog_function_enables[3]
                                   && !analog_function_enables[4];
        analog_o.thermistor_power = host_mode_o && analog_function_enables[5];
        analog_o.cell_amp_scale = operating_state[STATE_VSCALE_BIT];
        analog_o.current_amp_gain_select = operating_state[STATE_CURRENT_AMP_GAIN_SELECT_BIT];
    end

    assign balance_bypass_o = {analog_function_enables[7:6], balance_bypass_low};
    assign cell_sel_o = cell_translation_select;
    assign eeprom_enable_o = eeprom_write_enable;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    ee_code_a: assert property (reg_wr_i && reg_addr_i == ADDR_EE_EN |=>
        (eeprom_write_enable == EE_CODE_ACCESS || eeprom_write_enable == EE_CODE_WRITE
         || eeprom_write_enable == 8'h00))
        else $error("EEPROM enable holds an illegal code");
    parity_hold_a: assert property ($rose(parity_seen) |=> parity_seen [*4])
        else $error("Parity flag dropped");
    state_mask_a: assert property (operating_state[5:2] == 4'h0)
        else $error("Unused state bits not zero");
    release_block_a: assert property (volt_fault |=> rel_state != REL_DONE)
        else $error("Release went through during voltage fault");
    fet_host_a: assert property (!host_mode_o |-> !discharge_fet_o && !charge_fet_o)
        else $error("FET driven outside host mode");
    bat_prio_a: assert property (analog_o.supply_total_select |-> !analog_o.pack_total_select)
        else $error("Both total selects active");
    status_read_a: assert property (reg_addr_i == ADDR_STATUS |->
        reg_rdata_o[0] == (sense_i[0] | fault_latch[0]))
        else $error("Status bit zero wrong");
    tick_space_a: assert property (sample_tick_o |=> !sample_tick_o [*8])
        else $error("Sample ticks too close");

    // Status bits follow the live conditions while the status index is selected.
    ovl_seen_a: assert property (reg_addr_i == ADDR_STATUS |->
        !sense_i.discharge_overload_flag || reg_rdata_o[1])
        else $error("Overload flag missing from status");
    cell_seen_a: assert property (reg_addr_i == ADDR_STATUS |->
        (!sense_i.cell_high_fault || reg_rdata_o[2])
        && (!sense_i.cell_low_fault || reg_rdata_o[3]))
        else $error("Cell fault flag missing from status");
    live_bits_a: assert property (reg_addr_i == ADDR_STATUS |->
        reg_rdata_o[7:4] == {sense_i.charge_fet_on, sense_i.discharge_fet_on,
        sense_i.eeprom_supply_ok, sense_i.thermal_fault})
        else $error("Live status bits wrong");
    // A release in host mode with no live fault leaves the latch empty.
    latch_free_a: assert property (fault_latch_release_o && host_mode_o
        && sense_i[3:0] == 4'h0 |=> fault_latch[3:0] == 4'h0)
        else $error("Fault latch kept a released fault");
    // Shutdown needs both the request bit and a zero pack.
    shutdown_request_gate_a: assert property (!operating_state[STATE_SHUTDOWN_REQUEST_BIT] || !pack_zero_i
        |-> !shutdown_o)
        else $error("Shutdown without request and zero pack");

    release_c: cover property (fault_latch_release_o);
    shutdown_c: cover property (shutdown_o);
    ee_write_c: cover property (eeprom_write_enable == EE_CODE_WRITE);
    parity_c: cover property (parity_seen);
    fast_tick_c: cover property (sample_tick_o && output_drive[OUT_FAST_BIT]);

endmodule : bpr_regs

`default_nettype wire

// [verification/bpr_host_model.sv]
`timescale 1ns/1ns
`default_nettype none

// Host model: single-byte register writes and reads.
module bpr_host_model (
    // Clock.
    input wire logic clk_i,
    // Register port.
    output logic [3:0] addr_o,
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] wdata_o,
    input wire logic [7:0] rdata_i
);
    // Idle port at time zero.
    initial begin
        addr_o = 4'h0;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 8'h00;
    end

    // legal host writes
    // Callers keep unused state bits at zero; t_status writes before host mode is entered.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        wdata_o <= ~d;
    endtask : wr

    // Read data is combinational, so it is taken before the closing edge.
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(negedge clk_i);
        d = rdata_i;
        @(posedge clk_i);
        rd_o <= 1'b0;
    endtask : rd
endmodule : bpr_host_model

`default_nettype wire

// [verification/testbench.sv]
`timescale 1ns/1ns
`default_nettype none

module testbench
    import bpr_pkg::*;
();
    // Stimulus and observed signals.
    logic ref_clk_i;
    logic rst_n_i;
    bpr_sense_t sense;
    logic parity;
    logic pack_zero;
    logic [3:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic host_mode;
    logic rel_p;
    logic discharge_fet;
    logic charge_fet;
    logic alert_n;
    logic shutdown_request;
    logic tick;
    logic od_oe;
    bpr_analog_t analog;
    logic [9:0] bal;
    logic [7:0] cell_sel;
    logic [7:0] ee_en;
    logic [7:0] r;
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;
    int pulses = 0;
    localparam int LIMIT = 60000;

    bpr_regs dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .sense_i(sense), .parity_fault_i(parity), .pack_zero_i(pack_zero),
        .host_mode_o(host_mode), .fault_latch_release_o(rel_p),
        .discharge_fet_o(discharge_fet), .charge_fet_o(charge_fet), .fault_alert_n_o(alert_n),
        .shutdown_o(shutdown_request), .sample_tick_o(tick), .open_drain_output_oe_o(od_oe),
        .analog_o(analog), .balance_bypass_o(bal), .cell_sel_o(cell_sel),
        .eeprom_enable_o(ee_en));

    bpr_host_model host (.clk_i(ref_clk_i), .addr_o(addr), .wr_o(wr), .rd_o(rd),
        .wdata_o(wdata), .rdata_i(rdata));

    // Free-running 125 MHz clock.
    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end

    // Cycle count, release pulse count and hang guard.
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (rel_p === 1'b1) begin
            pulses <= pulses + 1;
        end
        if (cycles == LIMIT) begin
            fails++;
            test_done();
        end
    end

    task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk

    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    task automatic do_reset();
        @(posedge ref_clk_i);
        rst_n_i <= 1'b0;
        repeat (5) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
    endtask : do_reset

    task automatic rchk(input string n, input logic [3:0] a, input logic [7:0] e);
        host.rd(a, r);
        chk(n, 16'(r), 16'(e));
    endtask : rchk

    task automatic achk(input logic e);
        @(negedge ref_clk_i);
        chk("alert_n", 16'(alert_n), 16'(e));
    endtask : achk

    // Toggles the release bit and counts the pulses that follow.
    task automatic toggle_release(input int n);
        int p0;
        p0 = pulses;
        host.wr(ADDR_OUTPUT, 8'h01);
        host.wr(ADDR_OUTPUT, 8'h00);
        repeat (5) @(posedge ref_clk_i);
        chk("release_pulse", 16'(pulses - p0), 16'(n));
    endtask : toggle_release

    task automatic t_reset();
        for (int a = 0; a < 16; a++) begin
            rchk("reset_read", 4'(a), REG_RESET);
        end
        achk(1'b1);
        $display("reset test done");
    endtask : t_reset

    task automatic t_status();
        for (int b = 4; b < 8; b++) begin
            @(posedge ref_clk_i);
            sense <= bpr_sense_t'(8'(1 << b));
            rchk("status_live", ADDR_STATUS, 8'(1 << b));
            achk(b != 4);
        end
        host.wr(ADDR_STATUS, 8'h00);
        rchk("status_ro", ADDR_STATUS, 8'h80);
        sense <= '0;
        $display("status test done");
    endtask : t_status

    task automatic t_latch();
        host.wr(ADDR_STATE, 8'h02);
        for (int b = 0; b < 4; b++) begin
            @(posedge ref_clk_i);
            sense <= bpr_sense_t'(8'(1 << b));
            rchk("fault_live", ADDR_STATUS, 8'(1 << b));
            sense <= '0;
            achk(1'b0);
            rchk("fault_held", ADDR_STATUS, 8'(1 << b));
            toggle_release(1);
            achk(1'b0);
            rchk("fault_free", ADDR_STATUS, 8'h00);
            achk(1'b1);
        end
        @(posedge ref_clk_i);
        sense <= bpr_sense_t'(8'h04);
        toggle_release(0);
        sense <= '0;
        toggle_release(1);
        rchk("high_free", ADDR_STATUS, 8'h00);
        $display("latch test done");
    endtask : t_latch

    task automatic t_output();
        host.wr(ADDR_OUTPUT, 8'hff);
        rchk("out_mask", ADDR_OUTPUT, 8'h8f);
        @(negedge ref_clk_i);
        chk("pins", 16'({host_mode, discharge_fet, charge_fet, od_oe}), 16'hf);
        host.wr(ADDR_OUTPUT, 8'h02);
        @(negedge ref_clk_i);
        chk("pins", 16'({discharge_fet, charge_fet, od_oe}), 16'h4);
        host.wr(ADDR_OUTPUT, 8'h04);
        @(posedge ref_clk_i);
        parity <= 1'b1;
        @(posedge ref_clk_i);
        parity <= 1'b0;
        chk("pins", 16'({discharge_fet, charge_fet, od_oe}), 16'h2);
        host.wr(ADDR_OUTPUT, 8'h04);
        rchk("parity", ADDR_OUTPUT, 8'h44);
        host.wr(ADDR_STATE, 8'h00);
        @(negedge ref_clk_i);
        chk("pins", 16'({host_mode, discharge_fet, charge_fet}), 16'h0);
        do_reset();
        rchk("parity_rst", ADDR_OUTPUT, 8'h00);
        $display("output test done");
    endtask : t_output

    task automatic t_config();
        logic [7:0] fv [8] = '{8'h01, 8'h02, 8'h04, 8'h09, 8'h11, 8'h19, 8'h21, 8'h08};
        logic [7:0] ev [4] = '{8'h62, 8'h41, 8'h55, 8'h62};
        logic [7:0] f;
        logic [7:0] e;
        host.wr(ADDR_STATE, 8'hc3);
        rchk("state_mask", ADDR_STATE, 8'hc3);
        chk("shutdown_request", 16'({host_mode, shutdown_request}), 16'h2);
        @(posedge ref_clk_i);
        pack_zero <= 1'b1;
        repeat (2) @(negedge ref_clk_i);
        chk("shutdown_request", 16'({host_mode, shutdown_request}), 16'h3);
        @(posedge ref_clk_i);
        pack_zero <= 1'b0;
        foreach (fv[i]) begin
            f = fv[i];
            host.wr(ADDR_STATE, i[0] ? 8'hc2 : 8'h02);
            host.wr(ADDR_FUNC, f);
            @(negedge ref_clk_i);
            e = {f[0], f[1], f[2], f[0] & f[3] & ~f[4], f[0] & f[4], f[5], i[0], i[0]};
            chk("analog", 16'(analog), 16'(e));
        end
        host.wr(ADDR_BAL_LOW, 8'ha5);
        host.wr(ADDR_FUNC, 8'h80);
        @(negedge ref_clk_i);
        chk("bypass", 16'(bal), 16'h2a5);
        host.wr(ADDR_CELL_SEL, 8'hff);
        rchk("cell_sel", ADDR_CELL_SEL, 8'h7f);
        chk("cell_sel_o", 16'(cell_sel), 16'h7f);
        for (int a = 6; a < 13; a++) begin
            host.wr(4'(a), 8'hff);
            rchk("cfg", 4'(a), (a == 7) ? 8'h7f : (a > 10) ? 8'h00 : 8'hff);
        end
        foreach (ev[i]) begin
            f = ev[i];
            e = (f == EE_CODE_ACCESS || f == EE_CODE_WRITE) ? f : 8'h00;
            host.wr(ADDR_EE_EN, f);
            rchk("ee_read", ADDR_EE_EN, e);
            chk("ee_out", 16'(ee_en), 16'(e));
        end
        $display("config test done");
    endtask : t_config

    task automatic wait_tick();
        repeat (13000) begin
            @(negedge ref_clk_i);
            if (tick === 1'b1) break;
        end
    endtask : wait_tick

    task automatic t_tick();
        int t0;
        host.wr(ADDR_STATE, 8'h02);
        host.wr(ADDR_OUTPUT, 8'h80);
        wait_tick();
        t0 = cycles;
        wait_tick();
        chk("tick_gap", 16'(cycles - t0), 16'(FAST_SAMPLE_CYC));
        $display("tick test done");
    endtask : t_tick

    // Main sequence.
    initial begin
        rst_n_i = 1'b0;
        sense = '0;
        parity = 1'b0;
        pack_zero = 1'b0;
        do_reset();
        t_reset();
        t_status();
        t_latch();
        t_output();
        t_config();
        t_tick();
        test_done();
    end
endmodule : testbench

`default_nettype wire
